// File: core/tce_pkg.sv
package tce_pkg;

   // register byte offsets on the apb window
   localparam logic [11:0] TCE_OFF_COUNT = 12'h000;
   localparam logic [11:0] TCE_OFF_CCA = 12'h004;
   localparam logic [11:0] TCE_OFF_CCB = 12'h008;
   localparam logic [11:0] TCE_OFF_PRESCALE = 12'h00c;
   localparam logic [11:0] TCE_OFF_MODE = 12'h010;
   localparam logic [11:0] TCE_OFF_OUTCTL = 12'h014;
   localparam logic [11:0] TCE_OFF_STATUS = 12'h018;
   localparam logic [11:0] TCE_OFF_CAPCTL = 12'h01c;
   localparam logic [11:0] TCE_MAP_LIMIT = 12'h01f;

   // reset values and the counter top value
   localparam logic [15:0] TCE_RST_CNT = 16'h0000;
   localparam logic [15:0] TCE_RST_CC = 16'h0000;
   localparam logic [7:0] TCE_RST_BYTE = 8'h00;
   localparam logic [15:0] TCE_CNT_MAX = 16'hffff;

   // mode_select field values (bits 3:2 of timer_mode_reg)
   localparam logic [1:0] TCE_MODE_STOP = 2'h0;
   localparam logic [1:0] TCE_MODE_RESTART = 2'h1;
   localparam logic [1:0] TCE_MODE_FREE = 2'h2;
   localparam logic [1:0] TCE_MODE_CLEAR = 2'h3;

   // clock select values (bits 1:0 of prescaler_edge_config)
   localparam logic [1:0] TCE_CLK_DIV0 = 2'h0;
   localparam logic [1:0] TCE_CLK_DIV1 = 2'h1;
   localparam logic [1:0] TCE_CLK_PIN = 2'h3;

   // edge select encodings
   localparam logic [1:0] TCE_EDGE_FALL = 2'h0;
   localparam logic [1:0] TCE_EDGE_RISE = 2'h1;
   localparam logic [1:0] TCE_EDGE_BOTH = 2'h3;

   // status bit positions
   localparam int TCE_ST_WRAP = 0;
   localparam int TCE_ST_CAPB = 1;
   localparam int TCE_ST_MATCHA = 2;

   // timing: system clock and the fixed pin-count filter rate
   localparam int TCE_PCLK_NS = 50;
   localparam int TCE_PIN_SAMPLE_LOG = 3;

   // prescaler_edge_config layout
   typedef struct packed {
      logic [1:0] secondary_edge_sel;
      logic [1:0] primary_edge_sel;
      logic [1:0] reserved;
      logic [1:0] clock_select;
   } tce_prescale_t;

   // timer_mode_reg layout
   typedef struct packed {
      logic [3:0] reserved;
      logic [1:0] mode_select;
      logic [1:0] spare;
   } tce_mode_t;

   // output_control_reg layout
   typedef struct packed {
      logic [5:0] reserved;
      logic match_toggle_enable;
      logic output_enable_bit;
   } tce_outctl_t;

   // capture control layout
   typedef struct packed {
      logic [4:0] reserved;
      logic capture_b_en;
      logic capture_a_inverse;
      logic capture_a_en;
   } tce_capctl_t;

endpackage

// File: core/tce_timer.sv
`timescale 1ns/10ps
module tce_timer
   import tce_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int DIV0_LOG = 1,
   parameter int DIV1_LOG = 3,
   parameter int DIV2_LOG = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic primary_timer_input,
   input wire logic secondary_timer_input,
   output logic timer_output_pin,
   output logic match_irq_a,
   output logic capture_irq_b
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // edge selection decode, shared by both input pins
   function automatic logic edge_ok(input logic [1:0] sel, input logic rise, input logic fall);
      logic ok;
      ok = 1'b0;
      case (sel)
         TCE_EDGE_FALL: ok = fall;
         TCE_EDGE_RISE: ok = rise;
         TCE_EDGE_BOTH: ok = rise | fall;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // low k bits of the prescaler equal to a value
   function automatic logic div_at(input logic [7:0] cnt, input int k, input logic [7:0] val);
      logic [7:0] mask;
      mask = 8'((1 << k) - 1);
      return (cnt & mask) == (val & mask);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [CNT_W-1:0] count_q; // up_counter_value
   logic [CNT_W-1:0] cca_q; // compare_capture_a
   logic [CNT_W-1:0] ccb_q; // compare_capture_b
   tce_prescale_t prescale_q; // prescaler_edge_config
   tce_mode_t mode_q; // timer_mode_reg
   tce_outctl_t outctl_q; // output_control_reg
   tce_capctl_t capctl_q; // capture control
   logic wrap_q; // wrap_flag
   logic capb_flag_q; // capture_irq_flag_b
   logic matcha_flag_q; // match / capture a flag
   logic wrap_win_q; // between wrap and the next count
   logic [7:0] div_q; // free-running prescaler
   logic [1:0] in_s1_q, in_s2_q; // pin synchronisers
   logic [1:0] samp_q; // previous filter sample
   logic [1:0] lvl_q; // accepted pin levels
   logic seen_run_q; // timer has run since reset
   logic pend_a_q, pend_b_q; // capture waiting for clock fall
   logic irq_a_pend_q, irq_b_pend_q; // irq waiting for clock rise
   logic tout_q; // square wave level
   logic match_irq_q, cap_irq_q; // irq pulses
   logic [31:0] rdata_q; // read data latch

   ////////////////////////////////////////////////////////////////////////
   // counter-width constants and read views

   // package values cut to the counter width; a narrow counter must still see its own top value
   localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(TCE_RST_CNT);
   localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(TCE_CNT_MAX);
   localparam logic [CNT_W-1:0] CC_ZERO = CNT_W'(TCE_RST_CC);

   // counter-wide values zero-extended onto the 32-bit read path
   wire [31:0] count_rd = 32'(count_q);
   wire [31:0] cca_rd = 32'(cca_q);
   wire [31:0] ccb_rd = 32'(ccb_q);

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   wire mapped = (paddr <= TCE_MAP_LIMIT) && (paddr[1:0] == 2'b00);
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pwrite & mapped;
   wire wr_cca = wr_en && (paddr == TCE_OFF_CCA);
   wire wr_ccb = wr_en && (paddr == TCE_OFF_CCB);
   wire wr_pre = wr_en && (paddr == TCE_OFF_PRESCALE);
   wire wr_mode = wr_en && (paddr == TCE_OFF_MODE);
   wire wr_out = wr_en && (paddr == TCE_OFF_OUTCTL);
   wire wr_stat = wr_en && (paddr == TCE_OFF_STATUS);
   wire wr_cap = wr_en && (paddr == TCE_OFF_CAPCTL);

   // zero-wait slave; unmapped or misaligned gets an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = rdata_q;

   // read mux; a count read only samples, never triggers a capture
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         TCE_OFF_COUNT: rd_mux = count_rd;
         TCE_OFF_CCA: rd_mux = cca_rd;
         TCE_OFF_CCB: rd_mux = ccb_rd;
         TCE_OFF_PRESCALE: rd_mux = {24'h000000, prescale_q};
         TCE_OFF_MODE: rd_mux = {24'h000000, mode_q};
         TCE_OFF_OUTCTL: rd_mux = {24'h000000, outctl_q};
         TCE_OFF_STATUS: rd_mux = {29'h0, matcha_flag_q, capb_flag_q, wrap_q};
         TCE_OFF_CAPCTL: rd_mux = {24'h000000, capctl_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // count clock generation

   wire [1:0] mode_sel = mode_q.mode_select;
   wire running = (mode_sel != TCE_MODE_STOP);
   wire clk_is_pin = (prescale_q.clock_select == TCE_CLK_PIN);

   // selected divider; prescaler runs freely so a start lands anywhere in a period
   logic rise_tick, fall_tick;
   always_comb begin
      case (prescale_q.clock_select)
         TCE_CLK_DIV0: begin
            rise_tick = div_at(div_q, DIV0_LOG, 8'h00);
            fall_tick = div_at(div_q, DIV0_LOG, 8'(1 << (DIV0_LOG - 1)));
         end
         TCE_CLK_DIV1: begin
            rise_tick = div_at(div_q, DIV1_LOG, 8'h00);
            fall_tick = div_at(div_q, DIV1_LOG, 8'(1 << (DIV1_LOG - 1)));
         end
         default: begin
            rise_tick = div_at(div_q, DIV2_LOG, 8'h00);
            fall_tick = div_at(div_q, DIV2_LOG, 8'(1 << (DIV2_LOG - 1)));
         end
      endcase
   end

   // pin as count clock uses the fixed fx/8 filter rate
   wire pin_samp = div_at(div_q, TCE_PIN_SAMPLE_LOG, 8'h00);
   wire samp_tick = clk_is_pin ? pin_samp : rise_tick;

   ////////////////////////////////////////////////////////////////////////
   // input filter: level accepted after two equal samples

   wire [1:0] stable = ~(in_s2_q ^ samp_q);
   wire [1:0] differs = in_s2_q ^ lvl_q;
   wire lvl_track = running | seen_run_q; // level frozen low until first run
   wire [1:0] chg = stable & differs & {2{samp_tick & lvl_track}};
   // edges only count while running
   wire [1:0] rise_v = chg & in_s2_q & {2{running}};
   wire [1:0] fall_v = chg & ~in_s2_q & {2{running}};

   wire pri_valid = edge_ok(prescale_q.primary_edge_sel, rise_v[0], fall_v[0]);
   wire sec_valid = edge_ok(prescale_q.secondary_edge_sel, rise_v[1], fall_v[1]);
   wire pri_both = (prescale_q.primary_edge_sel == TCE_EDGE_BOTH);
   wire [1:0] inv_sel = (prescale_q.primary_edge_sel == TCE_EDGE_RISE) ? TCE_EDGE_FALL : TCE_EDGE_RISE;
   wire pri_inverse = ~pri_both & edge_ok(inv_sel, rise_v[0], fall_v[0]);

   ////////////////////////////////////////////////////////////////////////
   // capture triggers

   // the pin cannot both clock and trigger a capture
   wire trig_b = pri_valid & ~clk_is_pin & ((mode_sel == TCE_MODE_RESTART) | capctl_q.capture_b_en);
   wire trig_a_src = capctl_q.capture_a_inverse ? (pri_inverse & ~clk_is_pin) : sec_valid;
   wire trig_a = capctl_q.capture_a_en & trig_a_src;
   // captures happen at the fall of the count clock
   wire do_cap_b = pend_b_q & fall_tick & running;
   wire do_cap_a = pend_a_q & fall_tick & running;
   wire restart_clr = do_cap_b & (mode_sel == TCE_MODE_RESTART);

   ////////////////////////////////////////////////////////////////////////
   // counting, match and wrap

   // pin edges count directly in event mode
   wire cnt_tick = running & (clk_is_pin ? pri_valid : rise_tick);
   // cca in capture use does not compare
   wire match_a = cnt_tick & ~capctl_q.capture_a_en & (count_q == cca_q);
   // an equal compare clears; a lower one is passed only after the wrap
   wire match_clr = match_a & (mode_sel == TCE_MODE_CLEAR);
   // top value cut from the 16-bit package value, so counters up to 16 bits wrap and flag
   wire wrap_evt = cnt_tick & (count_q == CNT_TOP);

   // next count: stop and restart clear, a tick advances or clears on match
   logic [CNT_W-1:0] count_d;
   always_comb begin
      if (!running) begin
         count_d = CNT_ZERO;
      end else if (restart_clr) begin
         count_d = CNT_ZERO;
      end else if (cnt_tick) begin
         count_d = match_clr ? CNT_ZERO : CNT_W'(count_q + 1'b1);
      end else begin
         count_d = count_q;
      end
   end

   // flag clear loses to a new event and to the post-wrap window
   wire clr_wrap = wr_stat & pwdata[TCE_ST_WRAP];
   wire wrap_d = wrap_evt | wrap_win_q | (wrap_q & ~clr_wrap);
   // capture flag sets even if a read is in flight
   wire capb_d = do_cap_b | (capb_flag_q & ~(wr_stat & pwdata[TCE_ST_CAPB]));
   wire matcha_d = match_a | do_cap_a | (matcha_flag_q & ~(wr_stat & pwdata[TCE_ST_MATCHA]));

   // square wave toggles on each compare hit
   wire toggle_en = outctl_q.output_enable_bit & outctl_q.match_toggle_enable;
   wire tout_d = (toggle_en & match_a) ? ~tout_q : tout_q;

   ////////////////////////////////////////////////////////////////////////
   // apb side and configuration registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         prescale_q <= TCE_RST_BYTE;
         mode_q <= TCE_RST_BYTE;
         outctl_q <= TCE_RST_BYTE;
         capctl_q <= TCE_RST_BYTE;
      end else begin
         // read data latched in the setup phase
         if (setup) begin
            rdata_q <= rd_mux;
         end
         // edge bits take whatever is written; software stops first
         if (wr_pre) begin
            prescale_q <= pwdata[7:0];
         end
         if (wr_mode) begin
            mode_q <= pwdata[7:0];
         end
         if (wr_out) begin
            outctl_q <= pwdata[7:0];
         end
         if (wr_cap) begin
            capctl_q <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture / compare registers; a capture overrides a write

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cca_q <= CC_ZERO;
         ccb_q <= CC_ZERO;
      end else begin
         if (do_cap_a) begin
            cca_q <= count_q;
         end else if (wr_cca) begin
            cca_q <= pwdata[CNT_W-1:0];
         end
         if (do_cap_b) begin
            ccb_q <= count_q;
         end else if (wr_ccb) begin
            ccb_q <= pwdata[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and filter state

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_s1_q <= 2'b00;
         in_s2_q <= 2'b00;
         samp_q <= 2'b00;
         lvl_q <= 2'b00; // low so a high pin shows one rise at first run
         seen_run_q <= 1'b0;
      end else begin
         in_s1_q <= {secondary_timer_input, primary_timer_input};
         in_s2_q <= in_s1_q;
         if (samp_tick) begin
            samp_q <= in_s2_q;
         end
         lvl_q <= lvl_q ^ chg;
         seen_run_q <= seen_run_q | running;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter, pending captures and status flags

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
         count_q <= CNT_ZERO;
         pend_a_q <= 1'b0;
         pend_b_q <= 1'b0;
         wrap_q <= 1'b0;
         wrap_win_q <= 1'b0;
         capb_flag_q <= 1'b0;
         matcha_flag_q <= 1'b0;
      end else begin
         div_q <= div_q + 8'h01;
         count_q <= count_d;
         // pending captures wait for the fall, dropped when stopped
         pend_a_q <= running & (trig_a | (pend_a_q & ~fall_tick));
         pend_b_q <= running & (trig_b | (pend_b_q & ~fall_tick));
         wrap_q <= wrap_d;
         // window lasts from the wrap to the next count clock
         if (wrap_evt) begin
            wrap_win_q <= 1'b1;
         end else if (cnt_tick | ~running) begin
            wrap_win_q <= 1'b0;
         end
         capb_flag_q <= capb_d;
         matcha_flag_q <= matcha_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt pulses and timer output

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_a_pend_q <= 1'b0;
         irq_b_pend_q <= 1'b0;
         match_irq_q <= 1'b0;
         cap_irq_q <= 1'b0;
         tout_q <= 1'b0;
      end else begin
         // capture irq held until the next rise of the count clock
         irq_a_pend_q <= running & (do_cap_a | (irq_a_pend_q & ~rise_tick));
         irq_b_pend_q <= running & (do_cap_b | (irq_b_pend_q & ~rise_tick));
         match_irq_q <= match_a | (irq_a_pend_q & rise_tick);
         cap_irq_q <= irq_b_pend_q & rise_tick;
         tout_q <= tout_d;
      end
   end

   assign match_irq_a = match_irq_q;
   assign capture_irq_b = cap_irq_q;
   // pin low whenever the output is disabled
   assign timer_output_pin = tout_q & outctl_q.output_enable_bit;

endmodule

// File: testbench/tce_timer_asserts.sv
`timescale 1ns/10ps
module tce_timer_asserts
   import tce_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_output_pin,
   input wire logic match_irq_a,
   input wire logic capture_irq_b
);
   logic [1:0] mode_q; // mirror of the running mode
   logic oe_q; // mirror of output enable
   logic tog_q; // mirror of toggle on match
   wire wr_acc = psel && penable && pwrite; // write lands at this edge
   wire rd_cnt = psel && penable && !pwrite && paddr == TCE_OFF_COUNT; // count read

   ////////////////////////////////////////
   // shadow the control bits that the rules hinge on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= TCE_MODE_STOP;
         oe_q <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         if (wr_acc && paddr == TCE_OFF_MODE) begin
            mode_q <= pwdata[3:2];
         end
         if (wr_acc && paddr == TCE_OFF_OUTCTL) begin
            oe_q <= pwdata[0];
            tog_q <= pwdata[1];
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // stop held for three edges: in-flight pulses have drained by then
   sequence s_access; psel && penable; endsequence
   sequence s_stopped; (mode_q == TCE_MODE_STOP) [*3]; endsequence

   a_ready_high: assert property (s_access |-> pready)
      else $error("pready low in access");
   a_err_unmapped: assert property (s_access ##0 (paddr > TCE_OFF_CAPCTL || paddr[1:0] != 2'h0)
      |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad address not refused");
   a_err_mapped: assert property (s_access ##0 (paddr <= TCE_OFF_CAPCTL && paddr[1:0] == 2'h0)
      |-> !pslverr) else $error("mapped address refused");
   a_capb_pulse: assert property ($rose(capture_irq_b) |=> !capture_irq_b)
      else $error("capture b request wider than one clock");
   a_match_pulse: assert property ($rose(match_irq_a) |=> !match_irq_a)
      else $error("match request wider than one clock");
   a_stop_silent: assert property (s_stopped |-> !capture_irq_b && !match_irq_a)
      else $error("request while stopped");
   a_stop_count: assert property (s_stopped ##0 rd_cnt |-> prdata == 32'h0)
      else $error("count not zero while stopped");
   a_out_gated: assert property (!oe_q && !$past(oe_q) |-> !timer_output_pin)
      else $error("output driven while disabled");
   a_out_cause: assert property ($changed(timer_output_pin) && oe_q && $past(oe_q) |-> $past(tog_q))
      else $error("output moved without toggle enable");
endmodule

bind tce_timer tce_timer_asserts tce_timer_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_output_pin(timer_output_pin), .match_irq_a(match_irq_a),
   .capture_irq_b(capture_irq_b));

// File: testbench/tce_pins_model.sv
`timescale 1ns/10ps
module tce_pins_model (
   input wire logic pclk,
   input wire logic timer_output_pin,
   output logic primary_timer_input,
   output logic secondary_timer_input
);
   int toggles = 0; // level changes seen at the load
   logic last_q = 1'b0; // load level one clock ago

   ////////////////////////////////////////
   // pins idle low until a scenario asks otherwise
   initial begin
      primary_timer_input = 1'b0;
      secondary_timer_input = 1'b0;
   end

   // count square wave edges as the load sees them
   always @(posedge pclk) begin
      if (timer_output_pin !== last_q) toggles++;
      last_q <= timer_output_pin;
   end

   // steady level, e.g. a pulled-up pin before start
   task automatic level(input logic v);
      @(posedge pclk);
      primary_timer_input <= v;
   endtask

   // one pulse; widths under two samples would be filtered away
   task automatic pulse(input logic sec, input int hi, input int lo);
      @(posedge pclk);
      if (sec) secondary_timer_input <= 1'b1;
      else primary_timer_input <= 1'b1;
      repeat (hi) @(posedge pclk);
      if (sec) secondary_timer_input <= 1'b0;
      else primary_timer_input <= 1'b0;
      repeat (lo) @(posedge pclk);
   endtask
endmodule

// File: testbench/tce_timer_tb.sv
`timescale 1ns/10ps
module tce_timer_tb;
   import tce_pkg::*;
   localparam int CW = 8; // narrow counter so a wrap fits the run
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin_a;
   logic pin_b;
   logic tout;
   logic irq_a;
   logic irq_b;
   logic [31:0] q;
   logic [31:0] v;
   logic [7:0] ev_cfg [3] = '{8'h03, 8'h13, 8'h33}; // pin clock: fall, rise, both
   int errors = 0;
   int checks = 0;
   int seed = 32'h1cbc5b0d;
   int n_a = 0; // match a pulses
   int n_b = 0; // capture b pulses
   int k;
   int hi;
   int t0;

   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (irq_a === 1'b1) n_a++;
      if (irq_b === 1'b1) n_b++;
   end

   tce_timer #(.CNT_W(CW)) tce_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .primary_timer_input(pin_a), .secondary_timer_input(pin_b), .timer_output_pin(tout),
      .match_irq_a(irq_a), .capture_irq_b(irq_b));
   tce_pins_model tce_pins_model_i (.pclk(pclk), .timer_output_pin(tout), .primary_timer_input(pin_a),
      .secondary_timer_input(pin_b));

   ////////////////////////////////////////
   // apb master: hold the request until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the watchdog ends a wait for the slave
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: read %h, want %h", $time, got, exp);
      end
   endtask

   // one count clock of slack: start and pins are not aligned to ticks
   task automatic near(input logic [31:0] got, input logic [31:0] exp);
      check((got + 1 >= exp && got <= exp + 1) ? exp : got, exp);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check(r & m, e);
   endtask

   // edge config is only touched with the timer stopped
   task automatic start(input logic [7:0] pre, input logic [7:0] cap, input logic [7:0] mode);
      wr(TCE_OFF_MODE, 32'h0);
      wr(TCE_OFF_PRESCALE, {24'h0, pre});
      wr(TCE_OFF_CAPCTL, {24'h0, cap});
      wr(TCE_OFF_MODE, {24'h0, mode});
   endtask

   function automatic logic [31:0] evt_exp(int e, int n);
      return 32'(e == 2 ? 2 * n : n);
   endfunction

   // a 2h+1 pclk pulse period spans h or h+1 ticks of pclk/2
   function automatic logic [31:0] rst_exp(int h);
      return 32'(h);
   endfunction

   function automatic logic [31:0] cnt_exp(int c);
      return 32'(256 >> (c == 0 ? 1 : (c == 1 ? 3 : 5)));
   endfunction

   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial begin
      repeat (80000) @(posedge pclk);
      errors++;
      conclude();
   end

   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) rd_chk(12'(a), 32'hffffffff, 32'h0);
      wr(TCE_OFF_COUNT, 32'h55);
      rd_chk(TCE_OFF_COUNT, 32'hffffffff, 32'h0);
      tce_pins_model_i.level(1'b1);
      start(8'h10, 8'h00, 8'h04);
      repeat (20) @(posedge pclk);
      check(32'(n_b), 32'h1);
      start(8'h10, 8'h00, 8'h04);
      repeat (20) @(posedge pclk);
      check(32'(n_b), 32'h1);
      tce_pins_model_i.level(1'b0);
      // restart measurement on falling then rising edges, reads racing captures
      for (int e = 0; e < 2; e++) begin
         hi = 20 + $unsigned($random(seed)) % 16;
         k = 2 + $unsigned($random(seed)) % 4;
         start(e ? 8'h10 : 8'h00, 8'h00, 8'h04);
         n_b = 0;
         fork
            repeat (k) tce_pins_model_i.pulse(1'b0, hi, hi);
            repeat (k * 8) apb(1'b0, TCE_OFF_CCB, 32'h0, q);
         join
         apb(1'b0, TCE_OFF_CCB, 32'h0, q);
         near(q, rst_exp(hi));
         check(32'(n_b), 32'(k));
         rd_chk(TCE_OFF_STATUS, 32'h2, 32'h2);
      end
      v = q;
      for (int c = 0; c < 3; c++) begin
         start(8'(c), 8'h00, 8'h08);
         repeat (256) @(posedge pclk);
         apb(1'b0, TCE_OFF_COUNT, 32'h0, q);
         near(q, cnt_exp(c));
      end
      rd_chk(TCE_OFF_CCB, 32'hffffffff, v);
      wr(TCE_OFF_CCA, 32'h5a);
      start(8'h30, 8'h03, 8'h08);
      repeat (3) tce_pins_model_i.pulse(1'b0, 24, 24);
      rd_chk(TCE_OFF_CCA, 32'hffffffff, 32'h5a);
      // rise selected: the inverse fall captures into a once, request at the next rise
      start(8'h10, 8'h03, 8'h08);
      n_a = 0;
      tce_pins_model_i.pulse(1'b0, 24, 24);
      check(32'(n_a), 32'h1);
      // event counting on each edge kind; pin-clocked b capture stays off
      for (int e = 0; e < 3; e++) begin
         start(ev_cfg[e], 8'h04, 8'h08);
         apb(1'b0, TCE_OFF_CCB, 32'h0, v);
         n_b = 0;
         k = 2 + $unsigned($random(seed)) % 4;
         repeat (k) tce_pins_model_i.pulse(1'b0, 30, 30);
         rd_chk(TCE_OFF_COUNT, 32'hffffffff, evt_exp(e, k));
         rd_chk(TCE_OFF_CCB, 32'hffffffff, v);
         check(32'(n_b), 32'h0);
      end
      wr(TCE_OFF_MODE, 32'h0);
      n_a = 0;
      n_b = 0;
      tce_pins_model_i.pulse(1'b0, 30, 30);
      tce_pins_model_i.pulse(1'b1, 30, 30);
      rd_chk(TCE_OFF_COUNT, 32'hffffffff, 32'h0);
      check(32'(n_a + n_b), 32'h0);
      wr(TCE_OFF_CCA, 32'h3);
      wr(TCE_OFF_OUTCTL, 32'h3);
      start(8'h13, 8'h00, 8'h0c);
      n_a = 0;
      t0 = tce_pins_model_i.toggles;
      repeat (8) tce_pins_model_i.pulse(1'b0, 30, 30);
      rd_chk(TCE_OFF_COUNT, 32'hffffffff, 32'h0);
      check(32'(n_a), 32'h2);
      check(32'(tce_pins_model_i.toggles - t0), 32'h2);
      // compare lowered under the count: must wrap before it matches
      wr(TCE_OFF_CCA, 32'hf0);
      start(8'h00, 8'h00, 8'h0c);
      wr(TCE_OFF_STATUS, 32'h7);
      q = 32'h0;
      t0 = 0;
      while (q <= 32'h40 && t0 < 400) begin
         apb(1'b0, TCE_OFF_COUNT, 32'h0, q);
         t0++;
      end
      wr(TCE_OFF_CCA, 32'h20);
      n_a = 0;
      repeat (300) @(posedge pclk);
      check(32'(n_a), 32'h0);
      repeat (200) @(posedge pclk);
      check(32'(n_a), 32'h1);
      rd_chk(TCE_OFF_STATUS, 32'h1, 32'h1);
      // slow clock: a clear right after the wrap does not stick
      start(8'h02, 8'h00, 8'h08);
      wr(TCE_OFF_STATUS, 32'h7);
      q = 32'h0;
      t0 = 0;
      while (q[TCE_ST_WRAP] !== 1'b1 && t0 < 4000) begin
         apb(1'b0, TCE_OFF_STATUS, 32'h0, q);
         t0++;
      end
      wr(TCE_OFF_STATUS, 32'h1);
      rd_chk(TCE_OFF_STATUS, 32'h1, 32'h1);
      repeat (40) @(posedge pclk);
      wr(TCE_OFF_STATUS, 32'h1);
      rd_chk(TCE_OFF_STATUS, 32'h1, 32'h0);
      conclude();
   end
endmodule
